// ==== front_end_model.sv ====
module front_end_model
	import pressure_switch_pkg::*;
(
	input  wire logic        ref_clk,
	output logic [PAR_W-1:0] pressure_in,
	output logic             settings_key,
	output logic             detail_key,
	output logic             confirm_key
);
	timeunit 1ns;
	timeprecision 1ns;

	// Idle: pressure inside the hysteresis band, keys up
	initial begin
		pressure_in = 16'h2400;
		{confirm_key, detail_key, settings_key} = 3'h0;
	end

	// Keys {confirm,detail,settings} held n cycles, then all released
	task automatic hold(input logic [2:0] k, input int n);
		@(posedge ref_clk);
		{confirm_key, detail_key, settings_key} <= k;
		repeat (n) @(posedge ref_clk);
		{confirm_key, detail_key, settings_key} <= 3'h0;
	endtask

	// Pressure steps just after an edge
	task automatic set_p(input logic [PAR_W-1:0] p);
		@(posedge ref_clk);
		pressure_in <= p;
	endtask
endmodule

// ==== pressure_switch_ctrl.sv ====
// Overview of operation
// - After reset all indicator segments light for one second, then display mode.
// - Hysteresis outputs start inactive when pressure lies inside the hysteresis band.
// - Settings key held continuously five seconds requests programming mode.
// - Non-zero password must be entered; match programs, mismatch returns to display.
// - Sixty seconds without keys while editing returns to display, value unchanged.
// - Detail and settings keys together leave programming for display mode.
// - Switch point held per output, limited 0.25 to 100 percent, default nominal.
// - Upper window limit per output, limited 0.25 to 100 percent, default nominal.
// - Reset point limited zero to switch point minus 0.25 percent, default nominal-10.
// - Lower window limit zero to upper minus 0.25 percent, default nominal minus 10.
// - Output asserts after switch condition persists for switch delay, 0 to 65 s.
// - Output deasserts after reset condition persists for release delay, 0 to 65 s.
// - Four output functions: hysteresis or window, open or closed; default open hysteresis.
// - Output drive polarity high side or low side, default high side.
// - Confirmed factory restore returns every parameter to its default value.
// - Analog scale start and end stored, default start and end of range.
// - Zero offset correction only accepted in programming mode.
// - Hysteresis: active from switch point rising until reset point falling.
// - Window: active between lower and upper limits, inactive outside.
module pressure_switch_ctrl
	import pressure_switch_pkg::*;
#(
	parameter int unsigned TICK_CYC = TICK_CYC_DEF
)
(
	input  wire logic             ref_clk,
	input  wire logic             arst_n,
	input  wire logic [PAR_W-1:0] pressure_in,
	input  wire logic             settings_key,
	input  wire logic             detail_key,
	input  wire logic             confirm_key,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [7:0]       paddr,
	input  wire logic [31:0]      pwdata,
	output logic [31:0]           prdata,
	output logic                  pready,
	output logic                  pslverr,
	output logic                  lamp_test_on,
	output logic [2:0]            mode_code,
	output logic [1:0]            switch_active,
	output logic [1:0]            switch_out,
	output logic [PAR_W-1:0]      pressure_comp,
	output logic [PAR_W-1:0]      analog_scale_start,
	output logic [PAR_W-1:0]      analog_scale_end
);

	localparam int unsigned KEY_SET = 0;
	localparam int unsigned KEY_DET = 1;
	localparam int unsigned KEY_CNF = 2;
	localparam int unsigned NKEY    = 3;

	typedef struct packed {
		mode_type                    mode;
		logic [TICK_W-1:0]           tick_cnt;
		logic [TIMER_W-1:0]          timer;
		logic                        start;
		logic                        pw_fail;
		logic [NKEY-1:0][2:0]        key_sync;
		logic [NKEY-1:0]             key_q;
		logic                        cnf_prev;
		logic [4:0]                  edit_sel;
		logic [PAR_W-1:0]            edit_val;
		par_arr_type                 par;
		logic [PAR_W-1:0]            offset;
		logic [31:0]                 prdata;
	} ctrl_state_type;

	ctrl_state_type q, d;
	logic [NKEY-1:0] key_pin;
	logic            tick;
	logic            wr;
	logic            both_keys;
	logic            any_key;
	logic            cnf_rise;
	logic            long_hold;
	logic            pass_match;
	logic            par_hit;
	logic            addr_ok;
	logic [7:0]      par_ofs;
	logic [4:0]      par_idx;
	logic [1:0]      chan_active;
	logic [1:0]      chan_level;

	// Clamp an edited value and keep dependent limits consistent
	function automatic par_arr_type commit_par(par_arr_type p, logic [4:0] idx,
			logic [PAR_W-1:0] v);
		par_arr_type r;
		logic [PAR_W-1:0] hi;
		logic [4:0] low;
		r   = p;
		hi  = '0;
		low = idx + PAR_LOW_OFS;
		if (idx < PAR_RP1) begin
			// Switch point or upper window limit
			hi = v < PCT_STEP ? PCT_STEP : (v > RANGE_FULL ? RANGE_FULL : v);
			r[idx] = hi;
			if (p[low] > hi - PCT_STEP) begin
				r[low] = hi - PCT_STEP;
			end
		end else if (idx < PAR_SD1) begin
			// Reset point or lower window limit below its partner
			hi = p[idx - PAR_LOW_OFS] - PCT_STEP;
			r[idx] = v > hi ? hi : v;
		end else if (idx < PAR_FN1) begin
			r[idx] = v > DELAY_MAX ? DELAY_MAX : v;
		end else if (idx < PAR_POL1) begin
			r[idx] = v & FUNC_MASK;
		end else if (idx < PAR_AST) begin
			r[idx] = v & POL_MASK;
		end else if (idx < PAR_PASS) begin
			r[idx] = v > RANGE_FULL ? RANGE_FULL : v;
		end else begin
			r[idx] = v;
		end
		return r;
	endfunction

	assign key_pin = {confirm_key, detail_key, settings_key};

	// Decode shared by next state, bus answer and checks
	always_comb begin
		tick       = q.tick_cnt == TICK_W'(TICK_CYC - 1);
		wr         = psel && penable && pwrite;
		both_keys  = q.key_q[KEY_SET] && q.key_q[KEY_DET];
		any_key    = |q.key_q;
		cnf_rise   = q.key_q[KEY_CNF] && !q.cnf_prev;
		long_hold  = q.key_q[KEY_SET] && !q.key_q[KEY_DET];
		pass_match = pwdata[PAR_W-1:0] == q.par[PAR_PASS];
		par_ofs    = paddr - REG_PARAM_BASE;
		par_idx    = par_ofs[6:2];
		par_hit    = paddr >= REG_PARAM_BASE && par_ofs[7:2] < 6'(NPAR) && paddr[1:0] == 2'h0;
		addr_ok    = par_hit || paddr == REG_CTRL || paddr == REG_STATUS
			|| paddr == REG_PASS_TRY || paddr == REG_EDIT_SEL || paddr == REG_EDIT_VAL;
	end

	// Offset is subtracted with a floor at zero
	assign pressure_comp = pressure_in > q.offset ? pressure_in - q.offset : '0;

	always_comb begin
		d          = q;
		d.start    = 1'b0;
		d.cnf_prev = q.key_q[KEY_CNF];
		d.tick_cnt = tick ? '0 : q.tick_cnt + 1'b1;

		// Keys: three stages, a change counts once the last two agree
		for (int k = 0; k < NKEY; k++) begin
			d.key_sync[k] = {q.key_sync[k][1:0], key_pin[k]};
			if (q.key_sync[k][1] == q.key_sync[k][2]) begin
				d.key_q[k] = q.key_sync[k][2];
			end
		end

		// Read data captured in the setup phase, so it comes from flops
		if (psel && !penable) begin
			d.prdata = '0;
			if (paddr == REG_STATUS) begin
				d.prdata = {23'h000000, q.pw_fail, chan_active, q.key_q, q.mode};
			end else if (paddr == REG_EDIT_SEL) begin
				d.prdata = 32'(q.edit_sel);
			end else if (paddr == REG_EDIT_VAL) begin
				d.prdata = 32'(q.edit_val);
			end else if (par_hit && par_idx != PAR_PASS) begin
				// Password does not read back from its slot; REG_EDIT_VAL shows it once selected
				d.prdata = 32'(q.par[par_idx]);
			end
		end

		case (q.mode)
			MODE_LAMP: begin
				if (q.timer == LAMP_TICKS) begin
					d.mode  = MODE_DISPLAY;
					d.timer = '0;
					d.start = 1'b1;
				end else if (tick) begin
					d.timer = q.timer + 1'b1;
				end
			end
			MODE_DISPLAY: begin
				if (!long_hold) begin
					d.timer = '0; // Any release restarts the hold
				end else if (q.timer == LONG_TICKS) begin
					d.timer   = '0;
					d.pw_fail = 1'b0;
					// Password demanded only when one is set
					d.mode = q.par[PAR_PASS] == PASS_NONE ? MODE_PROGRAM : MODE_PASSWORD;
				end else if (tick) begin
					d.timer = q.timer + 1'b1;
				end
			end
			MODE_PASSWORD: begin
				if (wr && paddr == REG_PASS_TRY) begin
					d.mode    = pass_match ? MODE_PROGRAM : MODE_DISPLAY;
					d.pw_fail = !pass_match;
				end
			end
			MODE_PROGRAM: begin
				if (both_keys) begin
					d.mode = MODE_DISPLAY;
				end else if (wr && paddr == REG_EDIT_SEL && pwdata[4:0] < 5'(NPAR)) begin
					d.mode     = MODE_EDIT;
					d.edit_sel = pwdata[4:0];
					d.edit_val = q.par[pwdata[4:0]];
					d.timer    = '0;
				end else if (wr && paddr == REG_CTRL) begin
					if (pwdata[CTRL_RESTORE]) begin
						d.par = par_defaults();
					end else if (pwdata[CTRL_ZERO]) begin
						d.offset = pressure_in;
					end
				end
			end
			MODE_EDIT: begin
				if (wr && paddr == REG_EDIT_VAL) begin
					d.edit_val = pwdata[PAR_W-1:0];
				end
				if (both_keys) begin
					d.mode = MODE_DISPLAY;
				end else if (cnf_rise) begin
					d.par  = commit_par(q.par, q.edit_sel, q.edit_val);
					d.mode = MODE_PROGRAM;
				end else if (any_key) begin
					d.timer = '0;
				end else if (q.timer == TIMEOUT_TICKS) begin
					d.mode = MODE_DISPLAY; // Staged value dropped
				end else if (tick) begin
					d.timer = q.timer + 1'b1;
				end
			end
			default: begin
				d.mode = MODE_DISPLAY;
			end
		endcase
	end

	// Defaults in reset are constants only; parameters start at factory values
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			q        <= '0;
			q.mode   <= MODE_LAMP;
			q.par    <= par_defaults();
		end else begin
			q <= d;
		end
	end

	// One switching channel per output
	for (genvar i = 0; i < 2; i++) begin : g_chan
		chan_cfg_type cfg;
		assign cfg.switch_point           = q.par[PAR_SP1 + 5'(i)];
		assign cfg.reset_point            = q.par[PAR_RP1 + 5'(i)];
		assign cfg.window_upper_limit     = q.par[PAR_WU1 + 5'(i)];
		assign cfg.window_lower_limit     = q.par[PAR_WL1 + 5'(i)];
		assign cfg.switch_delay           = q.par[PAR_SD1 + 5'(i)];
		assign cfg.release_delay          = q.par[PAR_RD1 + 5'(i)];
		assign cfg.output_function_select = q.par[PAR_FN1 + 5'(i)][1:0];
		assign cfg.output_drive_polarity  = q.par[PAR_POL1 + 5'(i)][0];
		switch_channel u_chan (
			.ref_clk   (ref_clk),
			.arst_n    (arst_n),
			.pressure  (pressure_comp),
			.cfg       (cfg),
			.tick      (tick),
			.start     (q.start),
			.active    (chan_active[i]),
			.out_level (chan_level[i])
		);
	end

	// Zero-wait APB slave; unmapped addresses answer with an error
	assign prdata             = q.prdata;
	assign pready             = 1'b1;
	assign pslverr            = psel && penable && !addr_ok;
	assign lamp_test_on       = q.mode == MODE_LAMP;
	assign mode_code          = q.mode;
	assign switch_active      = chan_active;
	assign switch_out         = chan_level;
	assign analog_scale_start = q.par[PAR_AST];
	assign analog_scale_end   = q.par[PAR_AEN];

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);

	a_lamp_hold: assert property (
		(q.mode == MODE_LAMP && q.timer < LAMP_TICKS) |=> q.mode == MODE_LAMP)
		else $error("lamp test ended early");
	a_lamp_exit: assert property (
		(q.mode == MODE_LAMP && q.timer == LAMP_TICKS) |=> q.mode == MODE_DISPLAY && q.start)
		else $error("lamp test did not end into display");
	a_no_early_entry: assert property (
		(q.mode == MODE_DISPLAY && q.timer < LONG_TICKS) |=> q.mode == MODE_DISPLAY)
		else $error("programming entered before long press");
	a_password_check: assert property (
		(q.mode == MODE_PASSWORD && wr && paddr == REG_PASS_TRY)
		|=> q.mode == ($past(pass_match) ? MODE_PROGRAM : MODE_DISPLAY))
		else $error("password result wrong");
	a_edit_timeout: assert property (
		(q.mode == MODE_EDIT && q.timer == TIMEOUT_TICKS && !any_key && !cnf_rise)
		|=> q.mode == MODE_DISPLAY && q.par == $past(q.par))
		else $error("edit timeout wrong");
	a_two_key_exit: assert property (
		((q.mode == MODE_PROGRAM || q.mode == MODE_EDIT) && both_keys)
		|=> q.mode == MODE_DISPLAY)
		else $error("two keys did not leave programming");
	a_limit_order: assert property (
		q.par[PAR_RP1] + PCT_STEP <= q.par[PAR_SP1] && q.par[PAR_SP1] >= PCT_STEP
		&& q.par[PAR_WL1] + PCT_STEP <= q.par[PAR_WU1] && q.par[PAR_SP1] <= RANGE_FULL)
		else $error("limit relation broken");
	a_restore_all: assert property (
		(q.mode == MODE_PROGRAM && !both_keys && wr && paddr == REG_CTRL
		&& pwdata[CTRL_RESTORE] && !(paddr == REG_EDIT_SEL)) |=> q.par == par_defaults())
		else $error("factory restore incomplete");
	a_zero_guard: assert property (
		(q.mode != MODE_PROGRAM) |=> $stable(q.offset))
		else $error("zero offset changed outside programming");
	a_commit_only: assert property (
		(q.mode == MODE_EDIT && !cnf_rise) |=> q.par == $past(q.par))
		else $error("parameter changed without confirm");

	c_enter_program: cover property (q.mode == MODE_DISPLAY ##1 q.mode == MODE_PROGRAM);
	c_commit: cover property (q.mode == MODE_EDIT && cnf_rise);
	c_timeout: cover property (q.mode == MODE_EDIT ##1 q.mode == MODE_DISPLAY);

endmodule

// ==== pressure_switch_output_menu_ctrl_tb.sv ====
module pressure_switch_output_menu_ctrl_tb
	import pressure_switch_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic             ref_clk = 1'b0;
	logic             arst_n = 1'b0;
	logic             psel;
	logic             penable;
	logic             pwrite;
	logic [7:0]       paddr;
	logic [31:0]      pwdata;
	logic [31:0]      prdata;
	logic             pready;
	logic             pslverr;
	logic             lamp;
	logic [2:0]       mode;
	logic [1:0]       act;
	logic [1:0]       sout;
	logic [PAR_W-1:0] comp;
	logic [PAR_W-1:0] ast;
	logic [PAR_W-1:0] aen;
	logic [PAR_W-1:0] p_in;
	logic             k_set;
	logic             k_det;
	logic             k_cnf;
	logic [31:0]      rd;
	logic             er;
	int               bad_count = 0;
	int               comparisons = 0;

	// Short tick so the slow timers fit the run
	pressure_switch_ctrl #(.TICK_CYC(4)) u_pressure_switch_ctrl (
		.ref_clk(ref_clk), .arst_n(arst_n), .pressure_in(p_in),
		.settings_key(k_set), .detail_key(k_det), .confirm_key(k_cnf),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.lamp_test_on(lamp), .mode_code(mode), .switch_active(act),
		.switch_out(sout), .pressure_comp(comp), .analog_scale_start(ast),
		.analog_scale_end(aen));
	front_end_model u_front_end_model (
		.ref_clk(ref_clk), .pressure_in(p_in), .settings_key(k_set),
		.detail_key(k_det), .confirm_key(k_cnf));

	always #20 ref_clk = ~ref_clk;

	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One APB transfer; request held until pready is seen at an edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		// A wait that runs out counts as a mismatch
		if (pready !== 1'b1) bad_count++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic par_is(input int i, input logic [15:0] exp);
		bus(1'b0, REG_PARAM_BASE + 8'(4 * i), 32'h0);
		chk("param", rd, {16'h0000, exp});
	endtask

	// Sampled on the falling edge, clear of register updates
	task automatic wm(input logic [2:0] m, input int lim);
		int n;
		n = 0;
		while (mode !== m && n < lim) begin
			@(negedge ref_clk);
			n++;
		end
		chk("mode", mode, m);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	task automatic edit(input logic [4:0] i, input logic [15:0] v);
		bus(1'b1, REG_EDIT_SEL, {27'h0, i});
		bus(1'b1, REG_EDIT_VAL, {16'h0, v});
		u_front_end_model.hold(3'h4, 8);
		wm(MODE_PROGRAM, 20);
	endtask

	task automatic enter(input logic [2:0] m);
		u_front_end_model.hold(3'h1, 2100);
		wm(m, 50);
	endtask

	task automatic leave();
		u_front_end_model.hold(3'h3, 8);
		wm(MODE_DISPLAY, 20);
	endtask

	task automatic t_start();
		cyc(390);
		chk("lamp", lamp, 1'b1);
		wm(MODE_DISPLAY, 40);
		chk("lamp", lamp, 1'b0);
		chk("act", act, 2'b00);
	endtask

	// Factory values, unmapped place, zero capture refused in display
	task automatic t_defaults();
		logic [15:0] e;
		for (int i = 0; i < NPAR; i++) begin
			e = (i < 4 || i == 17) ? NOMINAL : (i < 8) ? NOMINAL - TEN_PCT : 16'h0000;
			par_is(i, e);
		end
		chk("aen", aen, RANGE_FULL);
		chk("ast", ast, 16'h0000);
		bus(1'b0, 8'h30, 32'h0);
		chk("slverr", er, 1'b1);
		bus(1'b1, REG_CTRL, 32'h2);
		chk("comp", comp, 16'h2400);
	endtask

	task automatic t_hyst();
		u_front_end_model.set_p(RANGE_FULL);
		cyc(4);
		chk("act", act, 2'b11);
		chk("out", sout, 2'b11);
		u_front_end_model.set_p(16'h2400);
		cyc(4);
		chk("act", act, 2'b11);
		u_front_end_model.set_p(16'h2328);
		cyc(4);
		chk("act", act, 2'b00);
	endtask

	// Short hold refused, then limits clamped on confirm
	task automatic t_clamp();
		u_front_end_model.hold(3'h1, 1900);
		cyc(2);
		chk("mode", mode, MODE_DISPLAY);
		enter(MODE_PROGRAM);
		edit(4, 16'h2710);
		par_is(4, 16'h26F7);
		edit(0, 16'h0005);
		par_is(0, 16'h0019);
		par_is(4, 16'h0000);
		bus(1'b1, REG_CTRL, 32'h1);
		par_is(0, NOMINAL);
		par_is(4, NOMINAL - TEN_PCT);
	endtask

	task automatic t_delay();
		edit(8, 16'h000A);
		edit(14, 16'h0001);
		leave();
		u_front_end_model.set_p(RANGE_FULL);
		cyc(30);
		chk("act", act, 2'b10);
		cyc(25);
		chk("act", act, 2'b11);
		chk("out", sout, 2'b10);
		u_front_end_model.set_p(16'h2328);
		cyc(4);
		chk("act", act, 2'b00);
	endtask

	// Edit left alone until it times out, then window sense
	task automatic t_timeout();
		enter(MODE_PROGRAM);
		edit(12, {14'h0, FUNC_WNO});
		bus(1'b1, REG_EDIT_SEL, 32'h0);
		bus(1'b1, REG_EDIT_VAL, 32'h1000);
		par_is(0, NOMINAL);
		cyc(23600);
		chk("mode", mode, MODE_EDIT);
		wm(MODE_DISPLAY, 700);
		par_is(0, NOMINAL);
		u_front_end_model.set_p(16'h2400);
		cyc(60);
		chk("act", act[0], 1'b1);
		u_front_end_model.set_p(16'h2000);
		cyc(4);
		chk("act", act[0], 1'b0);
	endtask

	task automatic t_pass();
		enter(MODE_PROGRAM);
		edit(18, 16'h1234);
		leave();
		enter(MODE_PASSWORD);
		bus(1'b1, REG_PASS_TRY, 32'h1111);
		wm(MODE_DISPLAY, 10);
		enter(MODE_PASSWORD);
		bus(1'b1, REG_PASS_TRY, 32'h1234);
		wm(MODE_PROGRAM, 10);
		u_front_end_model.set_p(16'h0010);
		bus(1'b1, REG_CTRL, 32'h2);
		cyc(2);
		chk("comp", comp, 16'h0000);
		// Closed senses: both outputs inactive by pressure, so both read active
		edit(12, {14'h0, FUNC_WNC});
		edit(13, {14'h0, FUNC_HNC});
		chk("act", act, 2'b11);
	endtask

	// Reset, then the scenarios in order
	initial begin
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 8'h00;
		pwdata <= 32'h00000000;
		repeat (5) @(posedge ref_clk);
		chk("mode", mode, MODE_LAMP);
		arst_n <= 1'b1;
		t_start();
		t_defaults();
		t_hyst();
		t_clamp();
		t_delay();
		t_timeout();
		t_pass();
		results();
	end

	// Watchdog well past the expected 40k cycles
	initial begin
		repeat (60000) @(posedge ref_clk);
		bad_count++;
		results();
	end
endmodule

// ==== pressure_switch_pkg.sv ====
package pressure_switch_pkg;

	// Clock and the 10 ms time base everything slow is counted in
	localparam int unsigned CLK_HZ          = 25_000_000;
	localparam int unsigned TICK_MS         = 10;
	localparam int unsigned TICK_CYC_DEF    = CLK_HZ / 1000 * TICK_MS;
	localparam int unsigned TICK_W          = 24;

	// Mode timing, figures in ms, counts in ticks
	localparam int unsigned LAMP_TEST_MS    = 1000;
	localparam int unsigned LONG_PRESS_MS   = 5000;
	localparam int unsigned EDIT_TIMEOUT_MS = 60000;
	localparam int unsigned DELAY_MAX_MS    = 65000;
	localparam int unsigned TIMER_W         = 13;
	localparam logic [TIMER_W-1:0] LAMP_TICKS    = TIMER_W'(LAMP_TEST_MS / TICK_MS);
	localparam logic [TIMER_W-1:0] LONG_TICKS    = TIMER_W'(LONG_PRESS_MS / TICK_MS);
	localparam logic [TIMER_W-1:0] TIMEOUT_TICKS = TIMER_W'(EDIT_TIMEOUT_MS / TICK_MS);

	// Parameter values: pressure in 0.01 % of range, delays in 0.01 s
	localparam int unsigned PAR_W = 16;
	localparam int unsigned NPAR  = 19;
	localparam logic [PAR_W-1:0] RANGE_FULL = 16'h2710;
	localparam logic [PAR_W-1:0] NOMINAL    = RANGE_FULL;
	localparam logic [PAR_W-1:0] PCT_STEP   = 16'h0019;
	localparam logic [PAR_W-1:0] TEN_PCT    = 16'h03E8;
	localparam logic [PAR_W-1:0] DELAY_MAX  = PAR_W'(DELAY_MAX_MS / TICK_MS);
	localparam logic [PAR_W-1:0] PASS_NONE  = 16'h0000;
	localparam logic [PAR_W-1:0] FUNC_MASK  = 16'h0003;
	localparam logic [PAR_W-1:0] POL_MASK   = 16'h0001;

	// Parameter slots
	localparam logic [4:0] PAR_SP1  = 5'h00;
	localparam logic [4:0] PAR_WU1  = 5'h02;
	localparam logic [4:0] PAR_RP1  = 5'h04;
	localparam logic [4:0] PAR_WL1  = 5'h06;
	localparam logic [4:0] PAR_LOW_OFS = 5'h04;
	localparam logic [4:0] PAR_SD1  = 5'h08;
	localparam logic [4:0] PAR_RD1  = 5'h0A;
	localparam logic [4:0] PAR_FN1  = 5'h0C;
	localparam logic [4:0] PAR_POL1 = 5'h0E;
	localparam logic [4:0] PAR_AST  = 5'h10;
	localparam logic [4:0] PAR_AEN  = 5'h11;
	localparam logic [4:0] PAR_PASS = 5'h12;

	// Output function encoding
	localparam logic [1:0] FUNC_HNO = 2'h0;
	localparam logic [1:0] FUNC_HNC = 2'h1;
	localparam logic [1:0] FUNC_WNO = 2'h2;
	localparam logic [1:0] FUNC_WNC = 2'h3;
	localparam int unsigned FUNC_NC_BIT  = 0;
	localparam int unsigned FUNC_WIN_BIT = 1;

	// APB register map (byte addresses)
	localparam logic [7:0] REG_CTRL       = 8'h00;
	localparam logic [7:0] REG_STATUS     = 8'h04;
	localparam logic [7:0] REG_PASS_TRY   = 8'h08;
	localparam logic [7:0] REG_EDIT_SEL   = 8'h0C;
	localparam logic [7:0] REG_EDIT_VAL   = 8'h10;
	localparam logic [7:0] REG_PARAM_BASE = 8'h40;
	localparam int unsigned CTRL_RESTORE  = 0;
	localparam int unsigned CTRL_ZERO     = 1;

	typedef logic [NPAR-1:0][PAR_W-1:0] par_arr_type;

	typedef enum logic [2:0] {
		MODE_LAMP,
		MODE_DISPLAY,
		MODE_PASSWORD,
		MODE_PROGRAM,
		MODE_EDIT
	} mode_type;

	// Settings one switching output needs
	typedef struct packed {
		logic [PAR_W-1:0] switch_point;
		logic [PAR_W-1:0] reset_point;
		logic [PAR_W-1:0] window_upper_limit;
		logic [PAR_W-1:0] window_lower_limit;
		logic [PAR_W-1:0] switch_delay;
		logic [PAR_W-1:0] release_delay;
		logic [1:0]       output_function_select;
		logic             output_drive_polarity;
	} chan_cfg_type;

	function automatic par_arr_type par_defaults();
		par_arr_type p;
		p = '0;
		for (int i = 0; i < 2; i++) begin
			p[PAR_SP1 + 5'(i)] = NOMINAL;
			p[PAR_WU1 + 5'(i)] = NOMINAL;
			p[PAR_RP1 + 5'(i)] = NOMINAL - TEN_PCT;
			p[PAR_WL1 + 5'(i)] = NOMINAL - TEN_PCT;
			p[PAR_FN1 + 5'(i)] = {14'h0000, FUNC_HNO};
		end
		p[PAR_AEN] = RANGE_FULL;
		return p;
	endfunction

endpackage

// ==== switch_channel.sv ====
module switch_channel
	import pressure_switch_pkg::*;
(
	input  wire logic             ref_clk,
	input  wire logic             arst_n,
	input  wire logic [PAR_W-1:0] pressure,
	input  wire chan_cfg_type     cfg,
	input  wire logic             tick,
	input  wire logic             start,
	output logic                  active,
	output logic                  out_level
);

	typedef struct packed {
		logic             run;
		logic             sw;
		logic [PAR_W-1:0] cnt;
	} chan_state_type;

	chan_state_type q, d;
	logic is_win, is_nc, in_win, in_band, want_set, want_clr, goal;
	logic [PAR_W-1:0] lim;

	// Decide whether the pending change has held long enough
	always_comb begin
		d        = q;
		is_win   = cfg.output_function_select[FUNC_WIN_BIT];
		is_nc    = cfg.output_function_select[FUNC_NC_BIT];
		in_win   = pressure >= cfg.window_lower_limit && pressure <= cfg.window_upper_limit;
		in_band  = pressure > cfg.reset_point && pressure < cfg.switch_point;
		want_set = is_win ? in_win : pressure >= cfg.switch_point;
		want_clr = is_win ? !in_win : pressure <= cfg.reset_point;
		goal     = q.sw ? want_clr : want_set;
		lim      = q.sw ? cfg.release_delay : cfg.switch_delay;
		if (!q.run) begin
			if (start) begin
				d.run = 1'b1;
				// Start inside the band in the inactive sense
				d.sw  = !is_win && in_band && is_nc;
			end
		end else if (!goal) begin
			d.cnt = '0; // Interruption restarts the delay
		end else if (q.cnt >= lim) begin
			d.sw  = !q.sw;
			d.cnt = '0;
		end else if (tick) begin
			d.cnt = q.cnt + 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// Normally closed inverts the sense, low side inverts the pin
	assign active    = q.run && (q.sw ^ is_nc);
	assign out_level = active ^ cfg.output_drive_polarity;

	a_start_inactive: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(!q.run && start && !is_win && in_band) |=> !active)
		else $error("output active after start inside hysteresis band");
	a_no_cause_set: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(q.run && !q.sw && !want_set) |=> !q.sw)
		else $error("output switched without switching condition");
	a_zero_delay_set: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(q.run && !q.sw && want_set && cfg.switch_delay == '0) ##1 $stable(cfg) |-> q.sw)
		else $error("zero switch delay not immediate");
	a_no_cause_clr: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(q.run && q.sw && !want_clr) |=> q.sw)
		else $error("output released without reset condition");
	c_output_switch: cover property (@(posedge ref_clk) disable iff (!arst_n)
		q.run && !q.sw ##1 q.sw);

endmodule
